/* File: lci_addr_gen.sv */
`timescale 1ns/1ps
`include "lci_regs.svh"

module lci_addr_gen
    import lci_pkg::*;
(
    // operating mode and pieces of the address
    input lci_mode_e mode,
    input wire logic [31:0] base,
    input wire logic [15:0] offset,
    // resulting bus address
    output logic [31:0] addr
);
    logic [31:0] sum;

    // full-width add: a header past the segment end runs on, not wraps
    assign sum = base + {16'h0000, offset};

    always_comb begin
        case (mode)
            LCI_MODE_LEGACY: addr = sum & `LCI_LEGACY_MASK;
            LCI_MODE_SEG32: addr = sum;
            LCI_MODE_LINEAR: addr = base;
            default: addr = sum & `LCI_LEGACY_MASK;
        endcase
    end
endmodule

/* File: lci_init_port.sv */
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "lci_regs.svh"

// Summary of operation
// - attention after reset starts initialization
// - default configuration pointer at fixed address
// - byte order pin picks little or big
// - bus config byte read at base+2/+1
// - config byte sets mode, trigger, lock, polarity (trigger and lock bits are stored but unused)
// - read intermediate pointer, keep control block address
// - throttle timers disabled after reset
// - finish: clear busy, flag, clear command, interrupt
// - port word: address high, function low nibble
// - port command takes two 16-bit writes
// - test and dump areas aligned, test writes results
// - dump works even when device is stuck, unless a bus cycle is in flight and never acked
// - legacy mode masks the control block address to 24 bits
// - segmented mode uses 32-bit base
// - linear mode uses absolute addresses only
// - segment overrun continues, never wraps
module lci_init_port
    import lci_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // pins from the host
    input wire logic attention_strobe,
    input wire logic byte_order_select,
    input wire logic port_strobe,
    input wire logic [15:0] port_data,
    // shared memory bus master
    output lci_mem_req_s mem_o,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    // to the command unit and the host
    output logic int_out,
    output logic cmd_attention,
    output logic init_done,
    output logic [7:0] bus_cfg,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata
);
    import lci_pkg::*;

    typedef enum logic [3:0] {
        ST_WAIT_CA, ST_SYSBUS, ST_INTERMEDIATE_CONFIG_POINTER_PTR, ST_INTERMEDIATE_CONFIG_POINTER_LO, ST_INTERMEDIATE_CONFIG_POINTER_HI,
        ST_CLR_BUSY, ST_SCB_WR, ST_READY, ST_TEST0, ST_TEST1, ST_DUMP
    } lci_state_e;

    // pick the upper or lower half of a dword according to byte order
    function automatic logic [15:0] hi_half(input logic [31:0] d,
                                            input logic le);
        hi_half = le ? d[31:16] : d[15:0];
    endfunction

    function automatic logic [31:0] pack_halves(input logic [15:0] lo,
                                                input logic [15:0] hi,
                                                input logic le);
        pack_halves = le ? {hi, lo} : {lo, hi};
    endfunction

    lci_state_e state_q, state_d;
    lci_mem_req_s mem_q, mem_d;
    logic [31:0] scp_base_q, scp_base_d;
    logic [31:0] intermediate_config_pointer_q, intermediate_config_pointer_d;
    logic [31:0] scb_base_q, scb_base_d;
    logic [15:0] scb_offs_q, scb_offs_d;
    logic [31:0] area_q, area_d;
    logic [31:0] testsig_q, testsig_d;
    logic [7:0] cfg_q, cfg_d;
    logic [1:0] dump_idx_q, dump_idx_d;
    logic done_q, done_d;
    logic irq_q, irq_d;
    logic cmd_att_q, cmd_att_d;
    logic [31:0] rdata_q, rdata_d;
    logic [15:0] t_on_q;
    logic [15:0] t_off_q;

    lci_port_cmd_s port_cmd;
    logic port_halt;
    logic port_take;
    lci_mode_e mode;
    logic [31:0] scb_addr;
    logic mem_done;
    logic mem_idle;
    logic [31:0] port_addr;

    lci_port_capture u_port (
        .clock(clock),
        .srst(srst),
        .port_strobe(port_strobe),
        .port_data(port_data),
        .cmd_take(port_take),
        .cmd(port_cmd),
        .halt(port_halt)
    );

    assign mode = lci_mode_e'(cfg_q[`LCI_CFG_MODE_LSB +: 2]);

    lci_addr_gen u_addr (
        .mode(mode),
        .base(scb_base_q),
        .offset(scb_offs_q),
        .addr(scb_addr)
    );

    assign mem_done = mem_q.req && mem_ack;
    assign mem_idle = !mem_q.req;
    // a port command waits for the bus cycle in flight to finish
    assign port_take = port_cmd.valid && mem_idle;
    assign port_addr = port_cmd.word & `LCI_ALIGN_MASK;

    always_comb begin
        state_d = state_q;
        mem_d = mem_q;
        scp_base_d = scp_base_q;
        intermediate_config_pointer_d = intermediate_config_pointer_q;
        scb_base_d = scb_base_q;
        scb_offs_d = scb_offs_q;
        area_d = area_q;
        cfg_d = cfg_q;
        dump_idx_d = dump_idx_q;
        done_d = done_q;
        irq_d = irq_q;
        cmd_att_d = 1'b0;
        if (mem_done) begin
            mem_d.req = 1'b0;
        end
        case (state_q)
            ST_WAIT_CA: begin
                if (attention_strobe && !port_halt) begin
                    irq_d = 1'b0;
                    state_d = ST_SYSBUS;
                end
            end
            ST_SYSBUS: begin
                if (mem_idle && !port_halt) begin
                    mem_d = '{1'b1, 1'b0, scp_base_q, 32'h0, `LCI_BE_ALL};
                end else if (mem_done) begin
                    // little end at base+2, big end at base+1
                    cfg_d = byte_order_select ? mem_rdata[23:16]
                                              : mem_rdata[15:8];
                    state_d = ST_INTERMEDIATE_CONFIG_POINTER_PTR;
                end
            end
            ST_INTERMEDIATE_CONFIG_POINTER_PTR: begin
                if (mem_idle && !port_halt) begin
                    mem_d = '{1'b1, 1'b0, scp_base_q + `LCI_SCP_INTERMEDIATE_CONFIG_POINTER_OFFS,
                              32'h0, `LCI_BE_ALL};
                end else if (mem_done) begin
                    intermediate_config_pointer_d = mem_rdata;
                    state_d = ST_INTERMEDIATE_CONFIG_POINTER_LO;
                end
            end
            ST_INTERMEDIATE_CONFIG_POINTER_LO: begin
                if (mem_idle && !port_halt) begin
                    mem_d = '{1'b1, 1'b0, intermediate_config_pointer_q, 32'h0, `LCI_BE_ALL};
                end else if (mem_done) begin
                    scb_offs_d = (mode == LCI_MODE_LINEAR) ? 16'h0000
                               : hi_half(mem_rdata, byte_order_select);
                    state_d = ST_INTERMEDIATE_CONFIG_POINTER_HI;
                end
            end
            ST_INTERMEDIATE_CONFIG_POINTER_HI: begin
                if (mem_idle && !port_halt) begin
                    mem_d = '{1'b1, 1'b0, intermediate_config_pointer_q + `LCI_INTERMEDIATE_CONFIG_POINTER_BASE_OFFS,
                              32'h0, `LCI_BE_ALL};
                end else if (mem_done) begin
                    scb_base_d = mem_rdata;
                    state_d = ST_CLR_BUSY;
                end
            end
            ST_CLR_BUSY: begin
                if (mem_idle && !port_halt) begin
                    // busy byte sits in the half opposite the offset
                    mem_d = '{1'b1, 1'b1, intermediate_config_pointer_q, `LCI_BUSY_CLEAR,
                              byte_order_select ? `LCI_BE_LOW
                                                : `LCI_BE_HIGH};
                end else if (mem_done) begin
                    state_d = ST_SCB_WR;
                end
            end
            ST_SCB_WR: begin
                if (mem_idle && !port_halt) begin
                    // status flags set, command word cleared in one write
                    mem_d = '{1'b1, 1'b1, scb_addr,
                              pack_halves(`LCI_STAT_DONE | `LCI_STAT_IDLE,
                                          16'h0000, byte_order_select),
                              `LCI_BE_ALL};
                end else if (mem_done) begin
                    done_d = 1'b1;
                    irq_d = 1'b1;
                    state_d = ST_READY;
                end
            end
            ST_READY: begin
                // only now does attention reach the command unit
                if (attention_strobe) begin
                    cmd_att_d = 1'b1;
                    irq_d = 1'b0;
                end
            end
            ST_TEST0: begin
                if (mem_idle && !port_halt) begin
                    mem_d = '{1'b1, 1'b1, area_q, testsig_q,
                              `LCI_BE_ALL};
                end else if (mem_done) begin
                    state_d = ST_TEST1;
                end
            end
            ST_TEST1: begin
                if (mem_idle && !port_halt) begin
                    mem_d = '{1'b1, 1'b1, area_q + `LCI_RES_WORD_OFFS,
                              32'h0, `LCI_BE_ALL};
                end else if (mem_done) begin
                    state_d = ST_WAIT_CA;
                end
            end
            ST_DUMP: begin
                // a pending port command stops the dump between words
                if (mem_idle && !port_halt) begin
                    mem_d.req = 1'b1;
                    mem_d.we = 1'b1;
                    mem_d.be = `LCI_BE_ALL;
                    mem_d.addr = area_q + {28'h0, dump_idx_q, 2'h0};
                    case (dump_idx_q)
                        2'h0: mem_d.wdata = {24'h0, cfg_q};
                        2'h1: mem_d.wdata = scb_base_q;
                        2'h2: mem_d.wdata = {16'h0, scb_offs_q};
                        default: mem_d.wdata = {t_on_q, t_off_q};
                    endcase
                end else if (mem_done) begin
                    dump_idx_d = dump_idx_q + 2'h1;
                    if (dump_idx_q == `LCI_DUMP_LAST) begin
                        state_d = ST_WAIT_CA;
                    end
                end
            end
            default: state_d = ST_WAIT_CA;
        endcase
        // port commands override any state once no bus cycle is in flight, so a device stuck in a state still dumps
        if (port_take) begin
            case (port_cmd.word[3:0])
                `LCI_PORT_RESET: begin
                    state_d = ST_WAIT_CA;
                    done_d = 1'b0;
                    irq_d = 1'b0;
                    cfg_d = 8'h00;
                end
                `LCI_PORT_TEST: begin
                    area_d = port_addr;
                    done_d = 1'b0;
                    state_d = ST_TEST0;
                end
                `LCI_PORT_RELOC: scp_base_d = port_addr;
                `LCI_PORT_DUMP: begin
                    area_d = port_addr;
                    dump_idx_d = 2'h0;
                    done_d = 1'b0;
                    state_d = ST_DUMP;
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            state_q <= ST_WAIT_CA;
            mem_q <= '0;
            scp_base_q <= `LCI_SCP_DEFAULT;
            intermediate_config_pointer_q <= 32'h0;
            scb_base_q <= 32'h0;
            scb_offs_q <= 16'h0000;
            area_q <= 32'h0;
            cfg_q <= 8'h00;
            dump_idx_q <= 2'h0;
            done_q <= 1'b0;
            irq_q <= 1'b0;
            cmd_att_q <= 1'b0;
        end else begin
            state_q <= state_d;
            mem_q <= mem_d;
            scp_base_q <= scp_base_d;
            intermediate_config_pointer_q <= intermediate_config_pointer_d;
            scb_base_q <= scb_base_d;
            scb_offs_q <= scb_offs_d;
            area_q <= area_d;
            cfg_q <= cfg_d;
            dump_idx_q <= dump_idx_d;
            done_q <= done_d;
            irq_q <= irq_d;
            cmd_att_q <= cmd_att_d;
        end
    end

    // throttle timers: no load path here, so they stay disabled
    always_ff @(posedge clock) begin
        if (srst) begin
            t_on_q <= `LCI_TON_RST;
            t_off_q <= `LCI_TOFF_RST;
        end else begin
            t_on_q <= t_on_q;
            t_off_q <= t_off_q;
        end
    end

    // register port
    always_comb begin
        testsig_d = testsig_q;
        rdata_d = 32'h0;
        if (reg_wr && reg_addr == `LCI_REG_TESTSIG) begin
            testsig_d = reg_wdata;
        end
        if (reg_rd) begin
            case (reg_addr)
                `LCI_REG_STATUS: rdata_d = {24'h0, byte_order_select,
                                            port_halt, done_q, 1'b0,
                                            4'(state_q)};
                `LCI_REG_BUSCFG: rdata_d = {24'h0, cfg_q};
                `LCI_REG_SCBBASE: rdata_d = scb_base_q;
                `LCI_REG_SCBOFFS: rdata_d = {16'h0, scb_offs_q};
                `LCI_REG_SCPBASE: rdata_d = scp_base_q;
                `LCI_REG_TESTSIG: rdata_d = testsig_q;
                `LCI_REG_THROTTLE: rdata_d = {t_on_q, t_off_q};
                default: rdata_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            testsig_q <= `LCI_TESTSIG_RST;
            rdata_q <= 32'h0;
        end else begin
            testsig_q <= testsig_d;
            rdata_q <= rdata_d;
        end
    end

    // polarity applied in a flop so the pin has no gate after it
    logic int_pin_q;
    always_ff @(posedge clock) begin
        if (srst) begin
            int_pin_q <= 1'b0;
        end else begin
            int_pin_q <= irq_d ^ cfg_d[`LCI_CFG_POL_BIT];
        end
    end

    assign mem_o = mem_q;
    assign int_out = int_pin_q;
    assign cmd_attention = cmd_att_q;
    assign init_done = done_q;
    assign bus_cfg = cfg_q;
    assign reg_rdata = rdata_q;
endmodule

/* File: lci_init_port_checker.sv */
`timescale 1ns/1ps

module lci_init_port_checker
    import lci_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // watched pins
    input wire logic byte_order_select,
    input lci_pkg::lci_mem_req_s mem_o,
    input wire logic mem_ack,
    input wire logic int_out,
    input wire logic cmd_attention,
    input wire logic init_done,
    input wire logic [7:0] bus_cfg,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    // done and idle flags set, command half cleared
    logic [31:0] stat_w;
    assign stat_w = byte_order_select ? 32'h0000a000 : 32'ha0000000;

    chk_req_hold: assert property (mem_o.req && !mem_ack |=>
        mem_o.req && $stable(mem_o))
        else $error("memory request moved before ack");
    chk_req_drop: assert property (mem_o.req && mem_ack |=> !mem_o.req)
        else $error("memory request held after ack");
    chk_reset_quiet: assert property ($fell(srst) |->
        !init_done && !mem_o.req && bus_cfg == 8'h00 && !int_out)
        else $error("outputs not quiet after reset");
    chk_cmd_gate: assert property (cmd_attention |-> $past(init_done))
        else $error("command attention before init done");
    chk_done_write: assert property ($rose(init_done) |->
        $past(mem_ack && mem_o.we && mem_o.be == 4'hf && mem_o.wdata == stat_w))
        else $error("init done without status write");
    chk_int_level: assert property ($rose(init_done) |=>
        int_out == !bus_cfg[5])
        else $error("interrupt level wrong after init");
    chk_legacy_addr: assert property (mem_o.req && mem_o.we && !init_done &&
        bus_cfg[2:1] == 2'h0 && mem_o.wdata == stat_w |-> mem_o.addr[31:24] == 8'h00)
        else $error("legacy address above 24 bits");
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside its cycle");
endmodule

bind lci_init_port lci_init_port_checker lci_init_port_checker_inst (
    .clock(clock), .srst(srst), .byte_order_select(byte_order_select),
    .mem_o(mem_o), .mem_ack(mem_ack), .int_out(int_out),
    .cmd_attention(cmd_attention), .init_done(init_done), .bus_cfg(bus_cfg),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));

/* File: lci_mem_model.sv */
`timescale 1ns/1ps

module lci_mem_model
    import lci_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // memory bus from the device
    input lci_pkg::lci_mem_req_s mem_i,
    output logic mem_ack,
    output logic [31:0] mem_rdata,
    // answer after three wait cycles when set
    input wire logic slow
);
    logic [31:0] mem [logic [31:0]];
    logic [31:0] first_a;
    int n_acc;
    int n_wr;
    int cnt;

    always @(posedge clock) begin
        if (srst) begin
            mem_ack <= 1'b0;
            mem_rdata <= 32'h0;
            cnt = 0;
            n_acc = 0;
            n_wr = 0;
        end else if (mem_ack) begin
            mem_ack <= 1'b0;
            // data no longer valid: never leave the old value standing
            mem_rdata <= ~mem_rdata;
        end else if (mem_i.req && cnt < (slow ? 3 : 0)) begin
            cnt++;
        end else if (mem_i.req) begin
            cnt = 0;
            mem_ack <= 1'b1;
            if (n_acc == 0)
                first_a = mem_i.addr;
            n_acc++;
            if (!mem.exists(mem_i.addr))
                mem[mem_i.addr] = 32'h0;
            if (mem_i.we) begin
                n_wr++;
                for (int i = 0; i < 4; i++)
                    if (mem_i.be[i])
                        mem[mem_i.addr][8*i +: 8] = mem_i.wdata[8*i +: 8];
            end else
                mem_rdata <= mem[mem_i.addr];
        end else
            mem_rdata <= ~mem_rdata;
    end
endmodule

/* File: lci_pkg.sv */
package lci_pkg;

    typedef enum logic [1:0] {
        LCI_MODE_LEGACY = 2'h0,
        LCI_MODE_SEG32 = 2'h1,
        LCI_MODE_LINEAR = 2'h2
    } lci_mode_e;

    typedef struct packed {
        logic req;
        logic we;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [3:0] be;
    } lci_mem_req_s;

    typedef struct packed {
        logic valid;
        logic [31:0] word;
    } lci_port_cmd_s;

endpackage

/* File: lci_port_capture.sv */
`timescale 1ns/1ps
`include "lci_regs.svh"

module lci_port_capture
    import lci_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // port write strobe and data
    input wire logic port_strobe,
    input wire logic [15:0] port_data,
    // to the sequencer
    input wire logic cmd_take,
    output lci_port_cmd_s cmd,
    output logic halt
);
    logic second_q, second_d;
    logic halt_q, halt_d;
    logic [15:0] low_q, low_d;
    lci_port_cmd_s cmd_q, cmd_d;

    // first write halts and keeps the low half, second one executes
    always_comb begin
        second_d = second_q;
        halt_d = halt_q;
        low_d = low_q;
        cmd_d = cmd_q;
        if (cmd_take) begin
            cmd_d.valid = 1'b0;
            halt_d = 1'b0;
        end
        if (port_strobe && !cmd_q.valid) begin
            if (!second_q) begin
                low_d = port_data;
                halt_d = 1'b1;
                second_d = 1'b1;
            end else begin
                cmd_d.word = {port_data, low_q};
                cmd_d.valid = 1'b1;
                second_d = 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            second_q <= 1'b0;
            halt_q <= 1'b0;
            low_q <= 16'h0000;
            cmd_q <= '0;
        end else begin
            second_q <= second_d;
            halt_q <= halt_d;
            low_q <= low_d;
            cmd_q <= cmd_d;
        end
    end

    assign cmd = cmd_q;
    assign halt = halt_q;
endmodule

/* File: lci_regs.svh */
`ifndef LCI_REGS_SVH
`define LCI_REGS_SVH

// register port byte offsets
`define LCI_REG_STATUS 8'h00
`define LCI_REG_BUSCFG 8'h04
`define LCI_REG_SCBBASE 8'h08
`define LCI_REG_SCBOFFS 8'h0c
`define LCI_REG_SCPBASE 8'h10
`define LCI_REG_TESTSIG 8'h14
`define LCI_REG_THROTTLE 8'h18

// reset values
`define LCI_SCP_DEFAULT 32'h0ffffff4
`define LCI_TESTSIG_RST 32'h5a5a_0001
`define LCI_TON_RST 16'hffff
`define LCI_TOFF_RST 16'h0000

// structure offsets in bytes
`define LCI_SCP_INTERMEDIATE_CONFIG_POINTER_OFFS 32'h0000_0008
`define LCI_INTERMEDIATE_CONFIG_POINTER_BASE_OFFS 32'h0000_0004
`define LCI_RES_WORD_OFFS 32'h0000_0004
`define LCI_ALIGN_MASK 32'hffff_fff0

// bus configuration byte fields
`define LCI_CFG_MODE_LSB 1
`define LCI_CFG_TRIG_BIT 3
`define LCI_CFG_LOCK_BIT 4
`define LCI_CFG_POL_BIT 5
`define LCI_CFG_BE32_BIT 7

// control block status word flags
`define LCI_STAT_DONE 16'h8000
`define LCI_STAT_IDLE 16'h2000
`define LCI_BUSY_CLEAR 32'h0000_0000

// port access function codes
`define LCI_PORT_RESET 4'h0
`define LCI_PORT_TEST 4'h1
`define LCI_PORT_RELOC 4'h2
`define LCI_PORT_DUMP 4'h3

// misc encodings
`define LCI_BE_ALL 4'hf
`define LCI_BE_LOW 4'h3
`define LCI_BE_HIGH 4'hc
`define LCI_LEGACY_MASK 32'h00ff_ffff
`define LCI_DUMP_LAST 2'h3

`endif

/* File: testbench.sv */
`timescale 1ns/1ps

module testbench;
    import lci_pkg::*;

    typedef struct packed {
        logic bo;
        logic [7:0] cfg;
        logic [31:0] base;
        logic [15:0] off;
        logic [31:0] shared_control_block;
    } lci_row_s;

    localparam logic [31:0] SYSTEM_CONFIG_POINTER = 32'h0fff_fff4;
    localparam logic [31:0] INTERMEDIATE_CONFIG_POINTER = 32'h0000_2000;

    logic clock, srst, attention_strobe, byte_order_select, port_strobe;
    logic [15:0] port_data;
    lci_mem_req_s mem_o;
    logic mem_ack, int_out, cmd_attention, init_done, reg_wr, reg_rd, slow;
    logic [31:0] mem_rdata, reg_wdata, reg_rdata;
    logic [7:0] bus_cfg, reg_addr;
    int n_errors, n_checks;
    // mode rows: legacy masked, seg32 inverted int, linear, legacy
    lci_row_s rows [4] = '{
        '{1'b1, 8'h00, 32'h1234_0000, 16'h0100, 32'h0034_0100},
        '{1'b1, 8'h22, 32'h1234_0000, 16'h0100, 32'h1234_0100},
        '{1'b0, 8'h84, 32'h0040_3000, 16'h0080, 32'h0040_3000},
        '{1'b0, 8'h18, 32'h0000_6000, 16'h0040, 32'h0000_6040}};

    lci_init_port lci_init_port_inst (.clock(clock), .srst(srst),
        .attention_strobe(attention_strobe),
        .byte_order_select(byte_order_select), .port_strobe(port_strobe),
        .port_data(port_data), .mem_o(mem_o), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .int_out(int_out),
        .cmd_attention(cmd_attention), .init_done(init_done),
        .bus_cfg(bus_cfg), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    lci_mem_model lci_mem_model_inst (.clock(clock), .srst(srst),
        .mem_i(mem_o), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .slow(slow));

    always #2.5 clock = ~clock;

    function automatic logic [31:0] mw(input logic [31:0] a);
        return lci_mem_model_inst.mem[a];
    endfunction

    task automatic give_verdict;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, exp, input string what);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // 0: init_done equals val, 1: write count reaches val, 2: cmd pulse
    task automatic wait_until(input int which, input int val);
        int k;
        k = 0;
        #1;
        while (!((which == 0 && init_done === val[0]) ||
                 (which == 1 && lci_mem_model_inst.n_wr >= val) ||
                 (which == 2 && cmd_attention === 1'b1))) begin
            @(posedge clock);
            #1;
            k++;
            if (k > 500) begin
                n_errors++;
                $display("[FAIL] %0t wait ran out", $time);
                give_verdict();
            end
        end
    endtask

    task automatic do_reset;
        @(posedge clock);
        srst <= 1'b1;
        repeat (6) @(posedge clock);
        srst <= 1'b0;
    endtask

    task automatic attend;
        @(posedge clock);
        attention_strobe <= 1'b1;
        @(posedge clock);
        attention_strobe <= 1'b0;
    endtask

    task automatic port_cmd(input logic [31:0] w);
        @(posedge clock);
        port_strobe <= 1'b1;
        port_data <= w[15:0];
        @(posedge clock);
        port_data <= w[31:16];
        @(posedge clock);
        port_strobe <= 1'b0;
    endtask

    // a read compares against d, a write stores d
    task automatic reg_io(input logic wr, input logic [7:0] a,
                          input logic [31:0] d);
        @(posedge clock);
        reg_wr <= wr;
        reg_rd <= !wr;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
        if (!wr)
            check(reg_rdata, d, "register read");
    endtask

    task automatic run_init(input logic [31:0] a, input lci_row_s r);
        byte_order_select <= r.bo;
        lci_mem_model_inst.mem[a] = r.bo ? {8'h0, r.cfg, 16'h0}
                                         : {16'h0, r.cfg, 8'h0};
        lci_mem_model_inst.mem[a + 8] = INTERMEDIATE_CONFIG_POINTER;
        lci_mem_model_inst.mem[INTERMEDIATE_CONFIG_POINTER] = r.bo ? {r.off, 16'h0001}
                                            : {16'h0001, r.off};
        lci_mem_model_inst.mem[INTERMEDIATE_CONFIG_POINTER + 4] = r.base;
        lci_mem_model_inst.mem[r.shared_control_block] = 32'h1111_1111;
        repeat (3) @(posedge clock);
        check(lci_mem_model_inst.n_acc, 0, "fetch before attention");
        attend();
        wait_until(0, 1);
        check(lci_mem_model_inst.first_a, a, "first fetch");
        check(32'(bus_cfg), 32'(r.cfg), "bus config");
        check(mw(r.shared_control_block), r.bo ? 32'h0000a000 : 32'ha0000000,
              "status word");
        check(mw(INTERMEDIATE_CONFIG_POINTER), r.bo ? {r.off, 16'h0} : {16'h0, r.off},
              "busy byte");
        @(posedge clock);
        #1;
        check(32'(int_out), 32'(!r.cfg[5]), "interrupt");
        reg_io(1'b0, 8'h00, {24'h0, r.bo, 3'b010, 4'h7});
    endtask

    initial begin
        clock = 1'b0;
        srst = 1'b1;
        attention_strobe = 1'b0;
        byte_order_select = 1'b1;
        port_strobe = 1'b0;
        port_data = 16'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h0;
        reg_wdata = 32'h0;
        slow = 1'b0;
        n_errors = 0;
        n_checks = 0;
        for (int i = 0; i < 4; i++) begin
            do_reset();
            slow <= i[0];
            run_init(SYSTEM_CONFIG_POINTER, rows[i]);
        end
        attend();
        wait_until(2, 1);
        check(32'(int_out), 32'h0, "interrupt after attention");
        do_reset();
        reg_io(1'b0, 8'h10, SYSTEM_CONFIG_POINTER);
        reg_io(1'b0, 8'h18, 32'hffff_0000);
        reg_io(1'b0, 8'h40, 32'h0);
        reg_io(1'b1, 8'h14, 32'hc3c3_0f0f);
        reg_io(1'b0, 8'h14, 32'hc3c3_0f0f);
        port_cmd(32'h0000_3002);
        run_init(32'h0000_3000, '{1'b1, 8'h02, 32'h0001_0000, 16'h0200,
                 32'h0001_0200});
        reg_io(1'b0, 8'h10, 32'h0000_3000);
        port_cmd(32'h0000_4001);
        wait_until(1, lci_mem_model_inst.n_wr + 2);
        check(mw(32'h4000), 32'hc3c3_0f0f, "self-test result");
        check(mw(32'h4004), 32'h0, "self-test status");
        port_cmd(32'h0000_5003);
        wait_until(1, lci_mem_model_inst.n_wr + 4);
        check(mw(32'h5000), 32'h02, "dump config");
        check(mw(32'h5004), 32'h0001_0000, "dump base");
        check(mw(32'h5008), 32'h0000_0200, "dump offset");
        check(mw(32'h500c), 32'hffff_0000, "dump throttle");
        port_cmd(32'h0000_0000);
        repeat (2) @(posedge clock);
        wait_until(0, 0);
        check(32'(bus_cfg), 0, "config after port reset");
        repeat (10) @(posedge clock);
        attend();
        wait_until(0, 1);
        check(32'(bus_cfg), 32'h02, "reinit config");
        give_verdict();
    end
endmodule
